// File: hw/wit_pkg.sv
// Constants shared by the watchdog and interval timer block.
// Assumes a byte-addressed CPU bus with 32-bit addresses.
package wit_pkg;
   // Bus addresses
   localparam logic [31:0] ADDR_CTRL_RD = 32'hFFFF_8610;
   localparam logic [31:0] ADDR_CNT_RD = 32'hFFFF_8611;
   localparam logic [31:0] ADDR_CNT_CTRL_WR = 32'hFFFF_8610;
   localparam logic [31:0] ADDR_RST_WR = 32'hFFFF_8612;
   localparam logic [31:0] ADDR_RST_RD = 32'hFFFF_8613;
   // Write keys in the upper byte
   localparam logic [7:0] KEY_CNT = 8'h5A;
   localparam logic [7:0] KEY_CTRL = 8'hA5;
   localparam logic [7:0] KEY_RST_CFG = 8'h5A;
   localparam logic [7:0] KEY_RST_CLR = 8'hA5;
   localparam logic [7:0] RST_CLR_DATA = 8'h00;
   // timer_ctrl_status fields
   localparam int CTRL_OVF_BIT = 7;
   localparam int CTRL_MODE_BIT = 6;
   localparam int CTRL_EN_BIT = 5;
   localparam int CTRL_CKS_LSB = 0;
   localparam logic [7:0] CTRL_RSVD_ONES = 8'h18;
   // reset_ctrl_status fields
   localparam int RST_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
   localparam int RST_EN_BIT = 6;
   localparam int RST_TYPE_BIT = 5;
   localparam logic [7:0] RST_RSVD_ONES = 8'h1F;
   // Reset values and counter maximum
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [2:0] CKS_RESET = 3'h0;
   // Pulse lengths in system clock cycles, and prescaler divider width
   localparam int OVF_OUT_CYCLES = 128;
   localparam int INT_RST_CYCLES = 512;
   localparam int PRESC_BITS = 13;

   // Standby sequencing states
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_STANDBY = 3'b010,
      ST_WAKE = 3'b100
   } wit_state_t;

   // Log2 of the clock division picked by clock_select_field
   function automatic logic [3:0] wit_div_log2(input logic [2:0] sel);
      case (sel)
         3'h0: wit_div_log2 = 4'h1;
         3'h1: wit_div_log2 = 4'h6;
         3'h2: wit_div_log2 = 4'h7;
         3'h3: wit_div_log2 = 4'h8;
         3'h4: wit_div_log2 = 4'h9;
         3'h5: wit_div_log2 = 4'hA;
         3'h6: wit_div_log2 = 4'hC;
         default: wit_div_log2 = 4'hD;
      endcase
   endfunction
endpackage

// File: hw/wit_ctl_if.sv
// Internal carrier between the timer core, prescaler and pulse timers.
// Assumes all three parts share one clock.
`timescale 1ns/1ps
`default_nettype none
interface wit_ctl_if;
   logic presc_run;
   logic [2:0] presc_sel;
   logic tick;
   logic start_ovf;
   logic start_rst;
   logic ovf_busy;
   logic rst_busy;
   modport presc (input presc_run, input presc_sel, output tick);
   modport pulse (input start_ovf, input start_rst, output ovf_busy, output rst_busy);
   modport core (output presc_run, output presc_sel, output start_ovf, output start_rst,
                 input tick, input ovf_busy, input rst_busy);
endinterface
`default_nettype wire

// File: hw/wit_prescaler.sv
// Clock divider giving one-cycle count ticks at the selected rate.
// Assumes the core holds run low to restart the division.
`timescale 1ns/1ps
`default_nettype none
module wit_prescaler
   import wit_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   wit_ctl_if.presc ctl
);
   logic [PRESC_BITS-1:0] div_q, div_d;
   logic [PRESC_BITS-1:0] mask;

   // Free-running divider, cleared while stopped
   always_comb begin
      mask = PRESC_BITS'((14'h0001 << wit_div_log2(ctl.presc_sel)) - 14'h0001);
      div_d = ctl.presc_run ? div_q + 1'b1 : '0;
      ctl.tick = ctl.presc_run && ((div_q & mask) == mask);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end
endmodule
`default_nettype wire

// File: hw/wit_pulse.sv
// Two pulse timers: the overflow output pulse and the internal reset pulse.
// Assumes starts are one-cycle pulses from the core.
`timescale 1ns/1ps
`default_nettype none
module wit_pulse
   import wit_pkg::*;
#(
   parameter int OVF_LEN = OVF_OUT_CYCLES,
   parameter int RST_LEN = INT_RST_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   wit_ctl_if.pulse ctl
);
   logic [9:0] ovf_cnt_q, ovf_cnt_d;
   logic [9:0] rst_cnt_q, rst_cnt_d;

   // Pulse lengths must fit the 10-bit counters
   if (OVF_LEN < 1 || OVF_LEN > 1023 || RST_LEN < 1 || RST_LEN > 1023) begin : g_bad_len
      $error("wit_pulse: pulse lengths must be 1 to 1023");
   end

   always_comb begin
      ovf_cnt_d = ovf_cnt_q;
      rst_cnt_d = rst_cnt_q;
      if (ctl.start_ovf) begin
         ovf_cnt_d = 10'(OVF_LEN);
      end else if (ovf_cnt_q != 10'h000) begin
         ovf_cnt_d = ovf_cnt_q - 10'h001;
      end
      if (ctl.start_rst) begin
         rst_cnt_d = 10'(RST_LEN);
      end else if (rst_cnt_q != 10'h000) begin
         rst_cnt_d = rst_cnt_q - 10'h001;
      end
      ctl.ovf_busy = ovf_cnt_q != 10'h000;
      ctl.rst_busy = rst_cnt_q != 10'h000;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovf_cnt_q <= '0;
         rst_cnt_q <= '0;
      end else begin
         ovf_cnt_q <= ovf_cnt_d;
         rst_cnt_q <= rst_cnt_d;
      end
   end
endmodule
`default_nettype wire

// File: hw/wit_watchdog_timer.sv
// Top of the 8-bit watchdog and interval timer with its keyed registers.
// Assumes a synchronous CPU bus: one-cycle strobes, writes land in one cycle.
//
// What this block does
// - Watchdog mode when mode select and count enable are both one.
// - Watchdog overflow drives the active-low overflow output for 128 cycles.
// - With reset enabled, overflow raises a 512-cycle internal reset alongside it.
// - Reset type select picks power-on or manual internal reset.
// - Reset type zero means power-on, one means manual.
// - External reset pin beats a coincident overflow's internal reset and clears the watchdog flag.
// - Watchdog reset leaves pin gate, pin function and port registers alone.
// - Interval mode: mode select zero, enabled; each overflow requests an interrupt.
// - Interval overflow sets its flag and the interrupt in one cycle.
// - Interrupt follows the flag, never triggers transfers; handler clears flag.
// - Watchdog overflow sets the watchdog flag with the overflow output.
// - Standby entry refused while counting is enabled.
// - On wake, counter runs at old rate; rollover releases clocks, ends standby.
// - Counter and control share a word-only write address keyed 5A or A5.
// - Reset control register is written only by word writes at its address.
// - Key A5 with data 00 clears the watchdog flag only.
// - Key 5A copies data bits 6 and 5 into enable and type.
// - Byte reads: control at 8610, counter at 8611, reset control at 8613.
// - A counter write beats a coincident increment tick.
// - Reset disabled: overflow resets only the counter and control register.
// - Manual reset waits for bus end; dropped once the 512-cycle pulse expires.
// - Counter ticks at clock divided by 2,64,128,256,512,1024,4096 or 8192.
// - Counter held at zero while counting is disabled.
`timescale 1ns/1ps
`default_nettype none
module wit_watchdog_timer
   import wit_pkg::*;
#(
   parameter int OVF_LEN = OVF_OUT_CYCLES,
   parameter int RST_LEN = INT_RST_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic [31:0] BUS_ADDR,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic BUS_WORD,
   input wire logic [15:0] BUS_WDATA,
   output logic [7:0] BUS_RDATA,
   input wire logic BUS_CYCLE_END,
   input wire logic EXT_RESET_PIN_N,
   input wire logic STANDBY_REQ,
   input wire logic WAKE_EVENT,
   output logic OVERFLOW_OUT_N,
   output logic INT_RESET_POWER_ON,
   output logic INT_RESET_MANUAL,
   output logic INTERVAL_INTERRUPT,
   output logic STANDBY_ACTIVE,
   output logic STANDBY_REFUSED,
   output logic CLOCK_RELEASE
);
   wit_ctl_if ctl ();

   wit_prescaler u_presc (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .ctl(ctl.presc)
   );

   wit_pulse #(
      .OVF_LEN(OVF_LEN),
      .RST_LEN(RST_LEN)
   ) u_pulse (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .ctl(ctl.pulse)
   );

   // Register state
   logic [7:0] cnt_q, cnt_d;
   logic ovf_q, ovf_d;
   logic ovf_seen_q, ovf_seen_d;
   logic mode_q, mode_d;
   logic en_q, en_d;
   logic [2:0] cks_q, cks_d;
   logic watchdog_overflow_flag_q, watchdog_overflow_flag_d;
   logic reset_enable_bit_q, reset_enable_bit_d;
   logic reset_type_select_q, reset_type_select_d;
   logic [7:0] rdata_q, rdata_d;
   // Reset sequencing and standby state
   logic rst_type_q, rst_type_d;
   logic man_go_q, man_go_d;
   wit_state_t state_q, state_d;
   logic release_q, release_d;
   logic refused_q, refused_d;

   // Decode and events
   logic wr_word, wr_cnt, wr_ctrl, wr_rst_cfg, wr_rst_clr;
   logic counting, overflow, wd_ovf, it_ovf, wd_reset, pin_rst;
   logic [7:0] ctrl_rd, rst_rd;

   // Bus decode, word writes with keys only
   always_comb begin
      wr_word = BUS_WR && BUS_WORD;
      wr_cnt = wr_word && BUS_ADDR == ADDR_CNT_CTRL_WR && BUS_WDATA[15:8] == KEY_CNT;
      wr_ctrl = wr_word && BUS_ADDR == ADDR_CNT_CTRL_WR && BUS_WDATA[15:8] == KEY_CTRL;
      wr_rst_cfg = wr_word && BUS_ADDR == ADDR_RST_WR && BUS_WDATA[15:8] == KEY_RST_CFG;
      wr_rst_clr = wr_word && BUS_ADDR == ADDR_RST_WR && BUS_WDATA[15:8] == KEY_RST_CLR
                   && BUS_WDATA[7:0] == RST_CLR_DATA;
   end

   // Counting and overflow events
   always_comb begin
      pin_rst = !EXT_RESET_PIN_N;
      counting = en_q || state_q == ST_WAKE;
      ctl.presc_run = counting;
      ctl.presc_sel = cks_q;
      overflow = counting && ctl.tick && !wr_cnt && cnt_q == CNT_MAX;
      wd_ovf = overflow && en_q && mode_q && state_q == ST_RUN;
      it_ovf = overflow && en_q && !mode_q && state_q == ST_RUN;
      wd_reset = wd_ovf && reset_enable_bit_q && !pin_rst;
      ctl.start_ovf = wd_ovf;
      ctl.start_rst = wd_reset;
   end

   // Counter and control register next values
   always_comb begin
      cnt_d = cnt_q;
      ovf_d = ovf_q;
      ovf_seen_d = ovf_seen_q;
      mode_d = mode_q;
      en_d = en_q;
      cks_d = cks_q;
      if (counting && ctl.tick) begin
         cnt_d = cnt_q + 8'h01;
      end
      if (wr_cnt) begin
         cnt_d = BUS_WDATA[7:0];
      end
      // Flag clears only after it was read as one
      if (BUS_RD && BUS_ADDR == ADDR_CTRL_RD && ovf_q) begin
         ovf_seen_d = 1'b1;
      end
      if (wr_ctrl) begin
         mode_d = BUS_WDATA[CTRL_MODE_BIT];
         en_d = BUS_WDATA[CTRL_EN_BIT];
         cks_d = BUS_WDATA[CTRL_CKS_LSB +: 3];
         if (!BUS_WDATA[CTRL_OVF_BIT] && ovf_seen_q) begin
            ovf_d = 1'b0;
            ovf_seen_d = 1'b0;
         end
      end
      if (!en_d && state_q != ST_WAKE) begin
         cnt_d = CNT_RESET;
      end
      if (it_ovf) begin
         ovf_d = 1'b1;
      end
      // watchdog overflow clears counter and control
      if (wd_ovf) begin
         cnt_d = CNT_RESET;
         mode_d = 1'b0;
         en_d = 1'b0;
         cks_d = CKS_RESET;
         ovf_d = 1'b0;
         ovf_seen_d = 1'b0;
      end
   end

   // Reset control register next values
   always_comb begin
      watchdog_overflow_flag_d = watchdog_overflow_flag_q;
      reset_enable_bit_d = reset_enable_bit_q;
      reset_type_select_d = reset_type_select_q;
      if (wr_rst_clr) begin
         watchdog_overflow_flag_d = 1'b0;
      end
      if (wr_rst_cfg) begin
         reset_enable_bit_d = BUS_WDATA[RST_EN_BIT];
         reset_type_select_d = BUS_WDATA[RST_TYPE_BIT];
      end
      if (wd_ovf) begin
         watchdog_overflow_flag_d = 1'b1;
      end
      if (pin_rst) begin
         watchdog_overflow_flag_d = 1'b0;
      end
   end

   // Internal reset type latch and manual reset bus wait
   always_comb begin
      rst_type_d = rst_type_q;
      man_go_d = man_go_q;
      if (wd_reset) begin
         rst_type_d = reset_type_select_q;
         man_go_d = 1'b0;
      end else if (ctl.rst_busy && BUS_CYCLE_END) begin
         man_go_d = 1'b1;
      end else if (!ctl.rst_busy) begin
         man_go_d = 1'b0;
      end
   end

   // Standby entry and wake sequencing
   always_comb begin
      state_d = state_q;
      release_d = 1'b0;
      refused_d = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (STANDBY_REQ) begin
               if (en_q) begin
                  refused_d = 1'b1;
               end else begin
                  state_d = ST_STANDBY;
               end
            end
         end
         ST_STANDBY: begin
            if (WAKE_EVENT) begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (overflow) begin
               state_d = ST_RUN;
               release_d = 1'b1;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // Byte read data, registered
   always_comb begin
      ctrl_rd = CTRL_RSVD_ONES;
      ctrl_rd[CTRL_OVF_BIT] = ovf_q;
      ctrl_rd[CTRL_MODE_BIT] = mode_q;
      ctrl_rd[CTRL_EN_BIT] = en_q;
      ctrl_rd[CTRL_CKS_LSB +: 3] = cks_q;
      rst_rd = RST_RSVD_ONES;
      rst_rd[RST_WATCHDOG_OVERFLOW_FLAG_BIT] = watchdog_overflow_flag_q;
      rst_rd[RST_EN_BIT] = reset_enable_bit_q;
      rst_rd[RST_TYPE_BIT] = reset_type_select_q;
      rdata_d = rdata_q;
      if (BUS_RD) begin
         case (BUS_ADDR)
            ADDR_CTRL_RD: rdata_d = ctrl_rd;
            ADDR_CNT_RD: rdata_d = cnt_q;
            ADDR_RST_RD: rdata_d = rst_rd;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // All block state; this block holds none of the pin registers
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         cnt_q <= CNT_RESET;
         ovf_q <= 1'b0;
         ovf_seen_q <= 1'b0;
         mode_q <= 1'b0;
         en_q <= 1'b0;
         cks_q <= CKS_RESET;
         watchdog_overflow_flag_q <= 1'b0;
         reset_enable_bit_q <= 1'b0;
         reset_type_select_q <= 1'b0;
         rdata_q <= 8'h00;
         rst_type_q <= 1'b0;
         man_go_q <= 1'b0;
         state_q <= ST_RUN;
         release_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ovf_q <= ovf_d;
         ovf_seen_q <= ovf_seen_d;
         mode_q <= mode_d;
         en_q <= en_d;
         cks_q <= cks_d;
         watchdog_overflow_flag_q <= watchdog_overflow_flag_d;
         reset_enable_bit_q <= reset_enable_bit_d;
         reset_type_select_q <= reset_type_select_d;
         rdata_q <= rdata_d;
         rst_type_q <= rst_type_d;
         man_go_q <= man_go_d;
         state_q <= state_d;
         release_q <= release_d;
         refused_q <= refused_d;
      end
   end

   // Outputs
   assign BUS_RDATA = rdata_q;
   assign OVERFLOW_OUT_N = !ctl.ovf_busy;
   assign INT_RESET_POWER_ON = ctl.rst_busy && !rst_type_q;
   assign INT_RESET_MANUAL = ctl.rst_busy && rst_type_q && man_go_q;
   assign INTERVAL_INTERRUPT = ovf_q;
   assign STANDBY_ACTIVE = state_q != ST_RUN;
   assign STANDBY_REFUSED = refused_q;
   assign CLOCK_RELEASE = release_q;
endmodule
`default_nettype wire

// File: testbench/wit_cpu_model.sv
// CPU-side model: holds its current bus cycle open for a set time.
// Assumes start is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module wit_cpu_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [7:0] hold_len,
   output logic bus_cycle_end
);
   logic [7:0] left_q, left_d;
   always_comb begin
      left_d = left_q;
      if (start)
         left_d = hold_len;
      else if (left_q != 8'h00)
         left_d = left_q - 8'h01;
   end
   // Cycle count register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         left_q <= 8'h00;
      else
         left_q <= left_d;
   end
   assign bus_cycle_end = (left_q == 8'h00);
endmodule
`default_nettype wire

// File: testbench/wit_watchdog_timer_properties.sv
// Port-level checks for the watchdog and interval timer.
// Assumes it is bound onto the top module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module wit_watchdog_timer_properties
   import wit_pkg::*;
#(
   parameter int OVF_LEN = OVF_OUT_CYCLES,
   parameter int RST_LEN = INT_RST_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic BUS_RD,
   input wire logic [7:0] BUS_RDATA,
   input wire logic BUS_CYCLE_END,
   input wire logic EXT_RESET_PIN_N,
   input wire logic STANDBY_REQ,
   input wire logic OVERFLOW_OUT_N,
   input wire logic INT_RESET_POWER_ON,
   input wire logic INT_RESET_MANUAL,
   input wire logic INTERVAL_INTERRUPT,
   input wire logic STANDBY_ACTIVE,
   input wire logic STANDBY_REFUSED,
   input wire logic CLOCK_RELEASE
);
   logic [10:0] low_q, low_d, por_q, por_d;
   // Run lengths of the two pulses
   always_comb begin
      low_d = OVERFLOW_OUT_N ? 11'h000 : low_q + 11'h001;
      por_d = INT_RESET_POWER_ON ? por_q + 11'h001 : 11'h000;
   end
   // Run length registers
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         low_q <= 11'h000;
         por_q <= 11'h000;
      end else begin
         low_q <= low_d;
         por_q <= por_d;
      end
   end
   default clocking dc @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   a_ovf_pulse_len: assert property ($rose(OVERFLOW_OUT_N) |-> low_q == OVF_LEN)
      else $error("overflow output pulse length wrong");
   a_ovf_pulse_cap: assert property (low_q <= OVF_LEN)
      else $error("overflow output held too long");
   a_rst_pulse_len: assert property ($fell(INT_RESET_POWER_ON) |-> por_q == RST_LEN)
      else $error("internal reset pulse length wrong");
   a_rst_with_ovf: assert property ($rose(INT_RESET_POWER_ON) |->
      $fell(OVERFLOW_OUT_N) && $past(EXT_RESET_PIN_N))
      else $error("internal reset not aligned with overflow output");
   a_rst_one_type: assert property (!(INT_RESET_POWER_ON && INT_RESET_MANUAL))
      else $error("both reset types raised");
   a_manual_after_end: assert property ($rose(INT_RESET_MANUAL) |-> $past(BUS_CYCLE_END))
      else $error("manual reset before bus cycle end");
   a_ovf_no_irq: assert property ($fell(OVERFLOW_OUT_N) |-> !INTERVAL_INTERRUPT ##1 !INTERVAL_INTERRUPT)
      else $error("interrupt raised by watchdog overflow");
   a_rdata_holds: assert property (!$past(BUS_RD) |-> $stable(BUS_RDATA))
      else $error("read data changed without a read");
   a_refuse_pulse: assert property (STANDBY_REFUSED |->
      $past(STANDBY_REQ) && !STANDBY_ACTIVE ##1 !STANDBY_REFUSED)
      else $error("standby refusal wrong");
   a_standby_entry: assert property ($rose(STANDBY_ACTIVE) |-> $past(STANDBY_REQ))
      else $error("standby entered without request");
   a_release_ends: assert property (CLOCK_RELEASE |-> $past(STANDBY_ACTIVE) && !STANDBY_ACTIVE)
      else $error("standby not ended by clock release");
   c_ovf: cover property ($fell(OVERFLOW_OUT_N));
   c_manual: cover property ($rose(INT_RESET_MANUAL));
   c_refused: cover property (STANDBY_REFUSED);
   c_release: cover property (CLOCK_RELEASE);
endmodule
bind wit_watchdog_timer wit_watchdog_timer_properties #(.OVF_LEN(OVF_LEN), .RST_LEN(RST_LEN)) u_props (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA),
   .BUS_CYCLE_END(BUS_CYCLE_END), .EXT_RESET_PIN_N(EXT_RESET_PIN_N), .STANDBY_REQ(STANDBY_REQ),
   .OVERFLOW_OUT_N(OVERFLOW_OUT_N), .INT_RESET_POWER_ON(INT_RESET_POWER_ON),
   .INT_RESET_MANUAL(INT_RESET_MANUAL), .INTERVAL_INTERRUPT(INTERVAL_INTERRUPT),
   .STANDBY_ACTIVE(STANDBY_ACTIVE), .STANDBY_REFUSED(STANDBY_REFUSED), .CLOCK_RELEASE(CLOCK_RELEASE));
`default_nettype wire

// File: testbench/wit_watchdog_timer_bench.sv
// Self-checking bench for the watchdog and interval timer.
// Assumes short pulse lengths of 4 and 8 cycles for speed.
`timescale 1ns/1ps
`default_nettype none
module wit_watchdog_timer_bench;
   import wit_pkg::*;
   localparam int OL = 4;
   localparam int RL = 8;
   logic clk_sys = 1'b0;
   logic rst_b, bus_wr, bus_rd, bus_word, bus_cycle_end, ext_reset_pin_n, standby_req, wake_event, cpu_start;
   logic overflow_out_n, int_reset_power_on, int_reset_manual, interval_interrupt;
   logic standby_active, standby_refused, clock_release;
   logic [31:0] bus_addr;
   logic [15:0] bus_wdata;
   logic [7:0] bus_rdata, hold_len;
   int errors = 0;
   int num_checks = 0;
   int i, s;
   int ks[8] = '{1, 6, 7, 8, 9, 10, 12, 13};
   // Clock
   always #2 clk_sys = ~clk_sys;
   wit_watchdog_timer #(.OVF_LEN(OL), .RST_LEN(RL)) DUT (
      .CLK_SYS(clk_sys), .RST_B(rst_b), .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
      .BUS_WORD(bus_word), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata), .BUS_CYCLE_END(bus_cycle_end),
      .EXT_RESET_PIN_N(ext_reset_pin_n), .STANDBY_REQ(standby_req), .WAKE_EVENT(wake_event),
      .OVERFLOW_OUT_N(overflow_out_n), .INT_RESET_POWER_ON(int_reset_power_on),
      .INT_RESET_MANUAL(int_reset_manual), .INTERVAL_INTERRUPT(interval_interrupt),
      .STANDBY_ACTIVE(standby_active), .STANDBY_REFUSED(standby_refused), .CLOCK_RELEASE(clock_release));
   wit_cpu_model u_cpu (.clk(clk_sys), .rst_b(rst_b), .start(cpu_start), .hold_len(hold_len),
      .bus_cycle_end(bus_cycle_end));
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic w);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_word <= w;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(what, exp, bus_rdata);
   endtask
   task automatic sby(input logic [7:0] e_ref, input logic [7:0] e_act);
      @(posedge clk_sys);
      standby_req <= 1'b1;
      @(posedge clk_sys);
      standby_req <= 1'b0;
      #1;
      chk("refused", e_ref, 8'(standby_refused));
      chk("standby", e_act, 8'(standby_active));
   endtask
   // One watchdog overflow with the given reset setup, pin level and bus hold
   task automatic wd_case(input logic [15:0] cfg, input logic pin, input logic [7:0] busy,
      input logic [7:0] e_por, input logic [7:0] e_man, input logic [7:0] e_rst);
      logic [7:0] n_ovf, n_por, n_man;
      n_ovf = 8'h00;
      n_por = 8'h00;
      n_man = 8'h00;
      wr(ADDR_RST_WR, {KEY_RST_CLR, RST_CLR_DATA}, 1'b1);
      wr(ADDR_RST_WR, cfg, 1'b1);
      ext_reset_pin_n <= pin;
      hold_len <= busy;
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h60}, 1'b1);
      rd(ADDR_CTRL_RD, 8'h78, "ctrl_wd");
      wr(ADDR_CNT_CTRL_WR, {KEY_CNT, 8'hFE}, 1'b1);
      cpu_start <= 1'b1;
      for (int k = 0; k < 3 * RL + OL + 20; k++) begin
         @(posedge clk_sys);
         cpu_start <= 1'b0;
         #1;
         n_ovf = n_ovf + (overflow_out_n ? 8'h00 : 8'h01);
         n_por = n_por + 8'(int_reset_power_on);
         n_man = n_man + 8'(int_reset_manual);
      end
      chk("ovf_len", 8'(OL), n_ovf);
      chk("por_len", e_por, n_por);
      chk("man_seen", e_man, 8'(n_man != 8'h00));
      chk("man_short", 8'h01, 8'(n_man < 8'(RL)));
      ext_reset_pin_n <= 1'b1;
      rd(ADDR_CTRL_RD, 8'h18, "ctrl_after");
      rd(ADDR_CNT_RD, 8'h00, "cnt_after");
      rd(ADDR_RST_RD, e_rst, "rst_after");
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      bus_addr = 32'h0000_0000;
      bus_wdata = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_word = 1'b0;
      ext_reset_pin_n = 1'b1;
      standby_req = 1'b0;
      wake_event = 1'b0;
      cpu_start = 1'b0;
      hold_len = 8'h00;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(ADDR_CTRL_RD, 8'h18, "ctrl");
      rd(ADDR_CNT_RD, 8'h00, "cnt");
      rd(ADDR_RST_RD, 8'h1F, "rst");
      rd(32'hFFFF_8614, 8'h00, "unmapped");
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h60}, 1'b0);
      wr(ADDR_CNT_CTRL_WR, 16'h1260, 1'b1);
      rd(ADDR_CTRL_RD, 8'h18, "ctrl_refused");
      wr(ADDR_RST_WR, {KEY_RST_CFG, 8'h60}, 1'b0);
      rd(ADDR_RST_RD, 8'h1F, "rst_refused");
      // Interval mode overflow, then flag clear by the handler
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h20}, 1'b1);
      rd(ADDR_CTRL_RD, 8'h38, "ctrl_run");
      wr(ADDR_CNT_CTRL_WR, {KEY_CNT, 8'hFE}, 1'b1);
      for (i = 0; i < 20 && interval_interrupt !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk("iti", 8'h01, 8'(interval_interrupt));
      chk("ovf_out_idle", 8'h01, 8'(overflow_out_n));
      rd(ADDR_CTRL_RD, 8'hB8, "ctrl_ovf");
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h20}, 1'b1);
      #1;
      chk("iti_clr", 8'h00, 8'(interval_interrupt));
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h00}, 1'b1);
      wr(ADDR_CNT_CTRL_WR, {KEY_CNT, 8'h80}, 1'b1);
      rd(ADDR_CNT_RD, 8'h00, "cnt_held");
      // Counter write lands in the same cycle as the first tick after enable
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h20}, 1'b1);
      wr(ADDR_CNT_CTRL_WR, {KEY_CNT, 8'h40}, 1'b1);
      rd(ADDR_CNT_RD, 8'h40, "cnt_wr_wins");
      // Count rate of each slower clock division, two ticks each
      for (s = 1; s < 8; s++) begin
         wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h00}, 1'b1);
         wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h20 | 8'(s)}, 1'b1);
         repeat ((2 << ks[s]) + (1 << (ks[s] - 1)) - 3) @(posedge clk_sys);
         rd(ADDR_CNT_RD, 8'h02, "cnt_rate");
      end
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h00}, 1'b1);
      // Regular reloads keep the watchdog from overflowing
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h60}, 1'b1);
      for (i = 0; i < 4; i++) begin
         repeat (200) @(posedge clk_sys);
         wr(ADDR_CNT_CTRL_WR, {KEY_CNT, 8'h00}, 1'b1);
      end
      rd(ADDR_CTRL_RD, 8'h78, "wd_quiet");
      rd(ADDR_RST_RD, 8'h1F, "watchdog_overflow_flag_quiet");
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h00}, 1'b1);
      wd_case(16'h5A40, 1'b1, 8'h00, 8'(RL), 8'h00, 8'hDF);
      wr(ADDR_RST_WR, {KEY_RST_CLR, 8'h01}, 1'b1);
      rd(ADDR_RST_RD, 8'hDF, "watchdog_overflow_flag_kept");
      wr(ADDR_RST_WR, {KEY_RST_CLR, RST_CLR_DATA}, 1'b1);
      rd(ADDR_RST_RD, 8'h5F, "watchdog_overflow_flag_clr");
      wr(ADDR_RST_WR, {KEY_RST_CFG, 8'hE0}, 1'b1);
      rd(ADDR_RST_RD, 8'h7F, "rst_cfg");
      wd_case(16'h5A60, 1'b1, 8'h07, 8'h00, 8'h01, 8'hFF);
      wd_case(16'h5A60, 1'b1, 8'h1E, 8'h00, 8'h00, 8'hFF);
      wd_case(16'h5A00, 1'b1, 8'h00, 8'h00, 8'h00, 8'h9F);
      wd_case(16'h5A40, 1'b0, 8'h00, 8'h00, 8'h00, 8'h5F);
      // Standby refused while running, then entered, woken and released
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h20}, 1'b1);
      sby(8'h01, 8'h00);
      wr(ADDR_CNT_CTRL_WR, {KEY_CTRL, 8'h00}, 1'b1);
      sby(8'h00, 8'h01);
      @(posedge clk_sys);
      wake_event <= 1'b1;
      @(posedge clk_sys);
      wake_event <= 1'b0;
      for (i = 0; i < 700 && clock_release !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      chk("release", 8'h01, 8'(clock_release));
      @(posedge clk_sys);
      #1;
      chk("standby_end", 8'h00, 8'(standby_active));
      rd(ADDR_CTRL_RD, 8'h18, "ctrl_wake");
      end_of_test();
   end
   // Watchdog against a hung run
   initial begin
      #300000;
      errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
